// ---- shared/chpa_pkg.sv ----
// package for the charger host port and adapter-detect block
package chpa_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h09;
  localparam logic [7:0] CMD_CONFIG = 8'h12;
  localparam logic [7:0] CMD_CHG_CURRENT = 8'h14;
  localparam logic [7:0] CMD_CHG_VOLTAGE = 8'h15;
  localparam logic [7:0] CMD_IN_CURRENT = 8'h3F;
  localparam logic [7:0] CMD_MAKER_ID = 8'hFE;
  localparam logic [7:0] CMD_PART_ID = 8'hFF;
  // arbitrary identity values
  localparam logic [15:0] MAKER_ID_VAL = 16'h00A5;
  localparam logic [15:0] PART_ID_VAL = 16'h005A;
  localparam logic [15:0] CONFIG_RST = 16'h8000;
  localparam logic [15:0] CHG_CURRENT_RST = 16'h0000;
  localparam logic [15:0] CHG_VOLTAGE_RST = 16'h0000;
  localparam logic [15:0] IN_CURRENT_RST = 16'h0000;
  localparam int CFG_LONG_DEGLITCH_BIT = 15;
  localparam int CLK_HZ = 20000000;
  localparam int SHORT_DEGLITCH_MS = 150;
  localparam int LONG_DEGLITCH_MS = 1300;
  localparam int LOW_TIMEOUT_MS = 25;
  localparam int SHORT_DEGLITCH_CYC = CLK_HZ / 1000 * SHORT_DEGLITCH_MS;
  localparam int LONG_DEGLITCH_CYC = CLK_HZ / 1000 * LONG_DEGLITCH_MS;
  localparam int LOW_TIMEOUT_CYC = CLK_HZ / 1000 * LOW_TIMEOUT_MS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RXBYTE = 3'b001,
    ST_ACK = 3'b010,
    ST_TXBYTE = 3'b011,
    ST_HOSTACK = 3'b100,
    ST_IGNORE = 3'b101
  } chpa_state_t;

  // comparator results arriving from the analog front end
  typedef struct packed {
    logic supplyOk;
    logic senseAboveReset;
    logic senseAboveLow;
    logic senseAboveHigh;
    logic supplyAboveBattery;
  } chpa_comp_t;

  // power-path and charge controls
  typedef struct packed {
    logic adapterSwitchOn;
    logic reverseBlockSwitchOn;
    logic batterySwitchOn;
    logic chargeAllowed;
  } chpa_path_t;
endpackage

// ---- hdl/chpa_host_port.sv ----
// smbus word target and adapter-detect qualification for the charger
// Notes on behaviour
// - target only, fixed address, never initiates
// - only read-word and write-word supported
// - bus active only with supply and sense
// - start and stop framing on sda
// - sda changes only while scl low
// - eight-bit bytes msb first, rising sample
// - ninth clock carries receiver acknowledge
// - write-word: address, command, low, high
// - read-word: repeated start, low, high, nack
// - four setpoint words readable and writable
// - two identity words, read only
// - adapter good needs supply, window, headroom
// - first rise after reset uses short delay
// - selectable delay after drop and switch off
// - sense below reset forces long delay
// - config bit15 zero selects short delay
// - overvoltage: good low, switch off, battery
// - back in window: adapter path resumes
// - long clock low abandons the transfer
`timescale 1ns/1ps
`default_nettype none

module chpa_host_port #(
  parameter int SHORT_CYC = chpa_pkg::SHORT_DEGLITCH_CYC,
  parameter int LONG_CYC = chpa_pkg::LONG_DEGLITCH_CYC,
  parameter int TIMEOUT_CYC = chpa_pkg::LOW_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire chpa_pkg::chpa_comp_t compIn,
  output logic adapterGoodOut,
  output logic adapterGoodOe,
  output chpa_pkg::chpa_path_t pathOut,
  output logic [15:0] batteryCurrentSetpoint,
  output logic [15:0] batteryVoltageSetpoint,
  output logic [15:0] adapterCurrentSetpoint,
  output logic [15:0] chargerConfigWord
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers
  logic [1:0] sclSync, sdaSync;
  logic [4:0] compS1, compS2;
  logic sclD, sdaD;
  always_ff @(posedge mclk) begin
    // comparators sync through reset: a zeroed stage would fake a sense reset at release
    compS1 <= compIn;
    compS2 <= compS1;
    if (rst) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      sclD <= 1'b1;
      sdaD <= 1'b1;
    end else begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      sclD <= sclSync[1];
      sdaD <= sdaSync[1];
    end
  end
  chpa_pkg::chpa_comp_t comp;
  assign comp = compS2;
  logic scl, sda, sclRise, sclFall, startSeen, stopSeen, busEnable;
  assign scl = sclSync[1];
  assign sda = sdaSync[1];
  assign sclRise = scl & ~sclD;
  assign sclFall = ~scl & sclD;
  assign startSeen = scl & sclD & sdaD & ~sda;
  assign stopSeen = scl & sclD & ~sdaD & sda;
  assign busEnable = comp.supplyOk & comp.senseAboveReset;

  ////////////////////////////////////////////////////////////////////////////
  // byte engine
  chpa_pkg::chpa_state_t state, next_state;
  logic [7:0] shiftReg, next_shiftReg, cmd, next_cmd, lowByte, next_lowByte;
  logic [3:0] bitCnt, next_bitCnt;
  logic [1:0] byteIdx, next_byteIdx;
  logic readMode, next_readMode, drive, next_drive, bitVal, next_bitVal;
  logic [15:0] txWord, next_txWord;
  logic [24:0] lowCnt, next_lowCnt;
  logic [15:0] cfg, next_cfg, chgCur, next_chgCur, chgVol, next_chgVol;
  logic [15:0] inCur, next_inCur;
  logic cfgWritten, next_cfgWritten;
  logic [15:0] readWord;

  always_comb begin
    unique case (cmd)
      chpa_pkg::CMD_CONFIG: readWord = cfg;
      chpa_pkg::CMD_CHG_CURRENT: readWord = chgCur;
      chpa_pkg::CMD_CHG_VOLTAGE: readWord = chgVol;
      chpa_pkg::CMD_IN_CURRENT: readWord = inCur;
      chpa_pkg::CMD_MAKER_ID: readWord = chpa_pkg::MAKER_ID_VAL;
      chpa_pkg::CMD_PART_ID: readWord = chpa_pkg::PART_ID_VAL;
      default: readWord = 16'h0000;
    endcase
  end

  always_comb begin
    next_state = state;
    next_shiftReg = shiftReg;
    next_cmd = cmd;
    next_lowByte = lowByte;
    next_bitCnt = bitCnt;
    next_byteIdx = byteIdx;
    next_readMode = readMode;
    next_drive = drive;
    next_bitVal = bitVal;
    next_txWord = txWord;
    next_cfg = cfg;
    next_chgCur = chgCur;
    next_chgVol = chgVol;
    next_inCur = inCur;
    next_cfgWritten = 1'b0;
    next_lowCnt = (scl || state == chpa_pkg::ST_IDLE) ? 25'h0000000 : lowCnt + 25'h0000001;
    if (!busEnable || stopSeen || lowCnt >= 25'(TIMEOUT_CYC)) begin
      next_state = chpa_pkg::ST_IDLE;
      next_drive = 1'b0;
    end else if (startSeen) begin
      next_state = chpa_pkg::ST_RXBYTE;
      next_bitCnt = 4'h0;
      next_byteIdx = 2'h0;
      next_drive = 1'b0;
    end else begin
      unique case (state)
        chpa_pkg::ST_IDLE, chpa_pkg::ST_IGNORE: next_drive = 1'b0;
        chpa_pkg::ST_RXBYTE: begin
          if (sclRise) begin
            next_shiftReg = {shiftReg[6:0], sda};
            next_bitCnt = bitCnt + 4'h1;
          end
          if (sclFall && bitCnt == 4'h8) begin
            next_state = chpa_pkg::ST_ACK;
            next_drive = 1'b1;
            next_bitVal = 1'b0;
            if (byteIdx == 2'h0) begin
              next_readMode = shiftReg[0];
              if (shiftReg[7:1] != chpa_pkg::DEV_ADDR) begin
                next_state = chpa_pkg::ST_IGNORE;
                next_drive = 1'b0;
              end
            end else if (byteIdx == 2'h1) begin
              next_cmd = shiftReg;
            end else if (byteIdx == 2'h2) begin
              next_lowByte = shiftReg;
            end else begin
              unique case (cmd)
                chpa_pkg::CMD_CONFIG: begin
                  next_cfg = {shiftReg, lowByte};
                  next_cfgWritten = 1'b1;
                end
                chpa_pkg::CMD_CHG_CURRENT: next_chgCur = {shiftReg, lowByte};
                chpa_pkg::CMD_CHG_VOLTAGE: next_chgVol = {shiftReg, lowByte};
                chpa_pkg::CMD_IN_CURRENT: next_inCur = {shiftReg, lowByte};
                default: next_cfgWritten = 1'b0;
              endcase
            end
          end
        end
        chpa_pkg::ST_ACK: begin
          if (sclFall) begin
            next_bitCnt = 4'h0;
            next_byteIdx = (byteIdx == 2'h3) ? 2'h3 : byteIdx + 2'h1;
            if (byteIdx == 2'h0 && readMode) begin
              next_state = chpa_pkg::ST_TXBYTE;
              next_txWord = readWord;
              next_drive = 1'b1;
              next_bitVal = readWord[7];
              next_shiftReg = {readWord[6:0], 1'b0};
            end else begin
              next_state = chpa_pkg::ST_RXBYTE;
              next_drive = 1'b0;
            end
          end
        end
        chpa_pkg::ST_TXBYTE: begin
          if (sclFall) begin
            next_bitCnt = bitCnt + 4'h1;
            if (bitCnt == 4'h7) begin
              next_state = chpa_pkg::ST_HOSTACK;
              next_drive = 1'b0;
            end else begin
              next_bitVal = shiftReg[7];
              next_shiftReg = {shiftReg[6:0], 1'b0};
            end
          end
        end
        chpa_pkg::ST_HOSTACK: begin
          if (sclRise) begin
            if (sda || byteIdx == 2'h2) begin
              next_state = chpa_pkg::ST_IGNORE;
            end else begin
              next_byteIdx = 2'h2;
              next_bitCnt = 4'h0;
            end
          end
          if (sclFall && state == next_state) begin
            next_state = chpa_pkg::ST_TXBYTE;
            next_drive = 1'b1;
            next_bitVal = txWord[15];
            next_shiftReg = {txWord[14:8], 1'b0};
          end
        end
        default: next_state = chpa_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !comp.senseAboveReset) begin
      state <= chpa_pkg::ST_IDLE;
      shiftReg <= 8'h00;
      cmd <= 8'h00;
      lowByte <= 8'h00;
      bitCnt <= 4'h0;
      byteIdx <= 2'h0;
      readMode <= 1'b0;
      drive <= 1'b0;
      bitVal <= 1'b1;
      txWord <= 16'h0000;
      lowCnt <= 25'h0000000;
      cfg <= chpa_pkg::CONFIG_RST;
      chgCur <= chpa_pkg::CHG_CURRENT_RST;
      chgVol <= chpa_pkg::CHG_VOLTAGE_RST;
      inCur <= chpa_pkg::IN_CURRENT_RST;
      cfgWritten <= 1'b0;
    end else begin
      state <= next_state;
      shiftReg <= next_shiftReg;
      cmd <= next_cmd;
      lowByte <= next_lowByte;
      bitCnt <= next_bitCnt;
      byteIdx <= next_byteIdx;
      readMode <= next_readMode;
      drive <= next_drive;
      bitVal <= next_bitVal;
      txWord <= next_txWord;
      lowCnt <= next_lowCnt;
      cfg <= next_cfg;
      chgCur <= next_chgCur;
      chgVol <= next_chgVol;
      inCur <= next_inCur;
      cfgWritten <= next_cfgWritten;
    end
  end

  // open drain: only ever pull low
  assign sdaOut = 1'b0;
  assign sdaOe = drive & ~bitVal;
  assign chargerConfigWord = cfg;
  assign batteryCurrentSetpoint = chgCur;
  assign batteryVoltageSetpoint = chgVol;
  assign adapterCurrentSetpoint = inCur;

  ////////////////////////////////////////////////////////////////////////////
  // adapter detect
  logic good, next_good, firstRise, next_firstRise, armed, next_armed;
  logic longSel, next_longSel, switchWasOff, next_switchWasOff;
  logic [25:0] dlyCnt, next_dlyCnt;
  logic qualify, inWindow, overVolt;
  assign inWindow = comp.senseAboveLow & ~comp.senseAboveHigh;
  assign overVolt = comp.senseAboveHigh;
  assign qualify = comp.supplyOk & inWindow & comp.supplyAboveBattery;

  always_comb begin
    next_good = good;
    next_firstRise = firstRise;
    next_armed = armed;
    next_longSel = longSel;
    next_switchWasOff = switchWasOff | ~good;
    next_dlyCnt = dlyCnt;
    if (cfgWritten) begin
      next_longSel = cfg[chpa_pkg::CFG_LONG_DEGLITCH_BIT];
    end
    if (comp.senseAboveReset && !comp.senseAboveLow && switchWasOff) begin
      next_armed = 1'b1;
    end
    if (!qualify) begin
      next_good = 1'b0;
      next_dlyCnt = 26'h0000000;
    end else if (!good) begin
      next_dlyCnt = dlyCnt + 26'h0000001;
      if ((firstRise || !armed || !longSel) ? dlyCnt >= 26'(SHORT_CYC)
          : dlyCnt >= 26'(LONG_CYC)) begin
        next_good = 1'b1;
        next_firstRise = 1'b0;
        next_armed = 1'b0;
        next_switchWasOff = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      good <= 1'b0;
      firstRise <= 1'b1;
      armed <= 1'b0;
      longSel <= 1'b1;
      switchWasOff <= 1'b0;
      dlyCnt <= 26'h0000000;
    end else if (!comp.senseAboveReset) begin
      good <= 1'b0;
      firstRise <= 1'b0;
      armed <= 1'b1;
      longSel <= 1'b1;
      switchWasOff <= 1'b1;
      dlyCnt <= 26'h0000000;
    end else begin
      good <= next_good;
      firstRise <= next_firstRise;
      armed <= next_armed;
      longSel <= next_longSel;
      switchWasOff <= next_switchWasOff;
      dlyCnt <= next_dlyCnt;
    end
  end

  // open drain pulls low unless good
  assign adapterGoodOut = 1'b0;
  assign adapterGoodOe = ~good;
  assign pathOut.adapterSwitchOn = good & ~overVolt;
  assign pathOut.reverseBlockSwitchOn = good & ~overVolt;
  assign pathOut.batterySwitchOn = ~good | overVolt;
  assign pathOut.chargeAllowed = good & ~overVolt;

endmodule // chpa_host_port
`default_nettype wire

// ---- dv/chpa_host_chk.sv ----
// assertion checker for the charger host port
`timescale 1ns/1ps
`default_nettype none
module chpa_host_chk #(
  parameter int SHORT_CYC = 50
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire chpa_pkg::chpa_comp_t compIn,
  input wire logic adapterGoodOut,
  input wire logic adapterGoodOe,
  input wire chpa_pkg::chpa_path_t pathOut,
  input wire logic [15:0] batteryCurrentSetpoint,
  input wire logic [15:0] chargerConfigWord
);
  logic qual;
  logic firstRise;
  logic next_firstRise;
  int qualCnt;
  int next_qualCnt;
  assign qual = compIn.supplyOk & compIn.senseAboveLow & ~compIn.senseAboveHigh
    & compIn.supplyAboveBattery;
  // pin-level count: never behind the synced count inside while qual holds
  always_comb begin
    next_qualCnt = qual ? qualCnt + 1 : 0;
    next_firstRise = firstRise & compIn.senseAboveReset & adapterGoodOe;
  end
  always_ff @(posedge mclk) begin
    qualCnt <= rst ? 0 : next_qualCnt;
    firstRise <= rst ? 1'b1 : next_firstRise;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_lost;
    !qual [*4];
  endsequence
  sequence s_ovp;
    compIn.senseAboveHigh [*4];
  endsequence
  sequence s_goodRise;
    $fell(adapterGoodOe);
  endsequence
  AST_OPEN_DRAIN: assert property (sdaOut == 1'b0 && adapterGoodOut == 1'b0)
    else $error("open drain output driven high");
  AST_SDA_SCL_LOW: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("sda moved while scl high");
  AST_NO_SUPPLY: assert property (!compIn.supplyOk [*4] |-> !sdaOe)
    else $error("bus driven without supply");
  AST_GOOD_NEEDS_QUAL: assert property (s_lost |-> adapterGoodOe)
    else $error("adapter good without qualify");
  AST_OVP_PATH: assert property (s_ovp |-> adapterGoodOe && !pathOut.adapterSwitchOn
    && !pathOut.chargeAllowed) else $error("overvoltage path wrong");
  AST_GOOD_PATH: assert property (s_goodRise |-> pathOut.adapterSwitchOn
    && pathOut.reverseBlockSwitchOn && !pathOut.batterySwitchOn) else $error("path at good");
  AST_DELAY_MIN: assert property (s_goodRise |-> qualCnt >= SHORT_CYC)
    else $error("adapter good too early");
  AST_FIRST_SHORT: assert property (s_goodRise and firstRise |-> qualCnt <= SHORT_CYC + 8)
    else $error("first good not short");
  AST_RESET_VALUES: assert property ($fell(rst) |-> chargerConfigWord == 16'h8000
    && batteryCurrentSetpoint == 16'h0000) else $error("reset values wrong");
  AST_SENSE_RESET: assert property (!compIn.senseAboveReset [*4]
    |-> chargerConfigWord == chpa_pkg::CONFIG_RST) else $error("sense reset missed");
  AST_COMMIT_AT_ACK: assert property ($changed(batteryCurrentSetpoint)
    && compIn.senseAboveReset |-> sdaOe || $past(sdaOe)) else $error("commit off ack");
endmodule // chpa_host_chk
`default_nettype wire

// ---- dv/chpa_smbus_host.sv ----
// embedded controller model: smbus master for word transfers
`timescale 1ns/1ps
`default_nettype none
module chpa_smbus_host (
  input wire logic mclk,
  input wire logic sdaWire,
  output logic scl,
  output logic sdaPull
);
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic start_cond();
    sdaPull <= 1'b0;
    tick(6);
    scl <= 1'b1;
    tick(4);
    sdaPull <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic stop_cond();
    sdaPull <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sdaPull <= 1'b0;
    tick(4);
  endtask
  task automatic bit_xfer(input logic b, output logic r);
    sdaPull <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(3);
    r = sdaWire;
    scl <= 1'b0;
    tick(1);
  endtask
  task automatic send_byte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, nack);
  endtask
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(last, r);
  endtask
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] d, output logic nack);
    logic [3:0] a;
    start_cond();
    send_byte({chpa_pkg::DEV_ADDR, 1'b0}, a[0]);
    send_byte(cmd, a[1]);
    send_byte(d[7:0], a[2]);
    send_byte(d[15:8], a[3]);
    stop_cond();
    nack = |a;
  endtask
  // read word, nack on high byte
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] d, output logic nack);
    logic [2:0] a;
    start_cond();
    send_byte({chpa_pkg::DEV_ADDR, 1'b0}, a[0]);
    send_byte(cmd, a[1]);
    start_cond();
    send_byte({chpa_pkg::DEV_ADDR, 1'b1}, a[2]);
    recv_byte(1'b0, d[7:0]);
    recv_byte(1'b1, d[15:8]);
    stop_cond();
    nack = |a;
  endtask
endmodule // chpa_smbus_host
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the charger host port
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int SHORT = 50;
  localparam int LONG = 200;
  localparam int TOUT = 400;
  typedef struct packed {logic [7:0] cmd; logic [15:0] wd; logic [15:0] rd;} chpa_row_t;
  chpa_row_t rows [8] = '{'{8'h14, 16'h1234, 16'h1234}, '{8'h15, 16'hABCD, 16'hABCD},
    '{8'h3F, 16'h0F80, 16'h0F80}, '{8'h12, 16'h7FFF, 16'h7FFF},
    '{8'hFE, 16'h1111, chpa_pkg::MAKER_ID_VAL}, '{8'hFF, 16'h2222, chpa_pkg::PART_ID_VAL},
    '{8'h20, 16'h3333, 16'h0000}, '{8'h14, 16'hFFFF, 16'hFFFF}};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  chpa_pkg::chpa_comp_t comp = 5'h1D;
  chpa_pkg::chpa_path_t path;
  logic scl, sdaPull, sdaOe, goodOe, nack;
  logic [15:0] cur, volt, inCur, cfg, rd;
  logic [2:0] acks;
  wire logic sdaWire;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  // pull-up: wire high unless someone pulls
  assign sdaWire = ~(sdaPull | sdaOe);
  always #25 mclk = ~mclk;
  chpa_host_port #(.SHORT_CYC(SHORT), .LONG_CYC(LONG), .TIMEOUT_CYC(TOUT)) chpa_host_port_inst (
    .mclk(mclk), .rst(rst), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(), .sdaOe(sdaOe),
    .compIn(comp), .adapterGoodOut(), .adapterGoodOe(goodOe), .pathOut(path),
    .batteryCurrentSetpoint(cur), .batteryVoltageSetpoint(volt),
    .adapterCurrentSetpoint(inCur), .chargerConfigWord(cfg));
  chpa_smbus_host chpa_smbus_host_inst (.mclk(mclk), .sdaWire(sdaWire), .scl(scl),
    .sdaPull(sdaPull));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic setc(input logic [4:0] v);
    @(posedge mclk);
    comp <= v;
  endtask
  // bounded wait for adapter good, delay must fall in window
  task automatic wait_good(input int lo, input int hi);
    int n;
    n = 0;
    while (goodOe !== 1'b0 && n <= hi) begin
      @(negedge mclk);
      n++;
    end
    chk(16'(n >= lo && n <= hi), 16'h0001);
    @(posedge mclk);
  endtask
  task automatic part(input logic [7:0] a, input logic [7:0] c, output logic [2:0] k);
    chpa_smbus_host_inst.start_cond();
    chpa_smbus_host_inst.send_byte(a, k[0]);
    chpa_smbus_host_inst.send_byte(c, k[1]);
    chpa_smbus_host_inst.send_byte(8'h00, k[2]);
    chpa_smbus_host_inst.stop_cond();
  endtask
  task automatic dip(input logic [4:0] v);
    setc(v);
    repeat (10) @(posedge mclk);
    chk(16'(goodOe), 16'h0001);
    setc(5'h1D);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    wait_good(SHORT, SHORT + 8);
    foreach (rows[i]) begin
      chpa_smbus_host_inst.write_word(rows[i].cmd, rows[i].wd, nack);
      chk(16'(nack), 16'h0000);
      chpa_smbus_host_inst.read_word(rows[i].cmd, rd, nack);
      chk(rd, rows[i].rd);
      chk(16'(nack), 16'h0000);
    end
    chk({cur ^ 16'hFFFF} | {volt ^ 16'hABCD} | {inCur ^ 16'h0F80} | {cfg ^ 16'h7FFF}, 16'h0000);
    // command and low byte only: word must not commit
    part({chpa_pkg::DEV_ADDR, 1'b0}, 8'h15, acks);
    chk(volt, 16'hABCD);
    part({7'h0A, 1'b0}, 8'h14, acks);
    chk(16'(acks), 16'h0007);
    chpa_smbus_host_inst.start_cond();
    chpa_smbus_host_inst.send_byte({chpa_pkg::DEV_ADDR, 1'b0}, nack);
    repeat (TOUT + 50) @(posedge mclk);
    chpa_smbus_host_inst.send_byte(8'h14, nack);
    chpa_smbus_host_inst.stop_cond();
    chk(16'(nack), 16'h0001);
    setc(5'h0D);
    repeat (6) @(posedge mclk);
    part({chpa_pkg::DEV_ADDR, 1'b0}, 8'h14, acks);
    chk(16'(acks), 16'h0007);
    setc(5'h1D);
    wait_good(SHORT, SHORT + 8);
    dip(5'h19);
    wait_good(SHORT, SHORT + 8);
    chpa_smbus_host_inst.write_word(8'h12, 16'h8000, nack);
    dip(5'h19);
    wait_good(LONG, LONG + 8);
    setc(5'h1F);
    repeat (6) @(posedge mclk);
    chk(16'({goodOe, path.adapterSwitchOn, path.chargeAllowed}), 16'h0004);
    setc(5'h1D);
    wait_good(SHORT, LONG + 8);
    chk(16'(path[3:1]), 16'h0006);
    // bit15 cleared first: sense reset must still restore config and force long
    chpa_smbus_host_inst.write_word(8'h12, 16'h7FFF, nack);
    dip(5'h11);
    chk(cfg, chpa_pkg::CONFIG_RST);
    wait_good(LONG, LONG + 8);
    report_and_stop();
  end
endmodule // tb
bind chpa_host_port chpa_host_chk #(.SHORT_CYC(SHORT_CYC)) chpa_host_chk_inst (
  .mclk(mclk), .rst(rst), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .compIn(compIn),
  .adapterGoodOut(adapterGoodOut), .adapterGoodOe(adapterGoodOe), .pathOut(pathOut),
  .batteryCurrentSetpoint(batteryCurrentSetpoint), .chargerConfigWord(chargerConfigWord));
`default_nettype wire
